// ===== src/cbr_cfg.svh
// constants for the compact branch resolve unit: opcodes, fields, register numbers
// assumes 32-bit instruction words and a 64-bit register file
`ifndef CBR_CFG_SVH
`define CBR_CFG_SVH

`define CBR_OP_MSB        31
`define CBR_OP_LSB        26
`define CBR_RS_MSB        25
`define CBR_RS_LSB        21
`define CBR_RT_MSB        20
`define CBR_RT_LSB        16
`define CBR_OFF16_MSB     15
`define CBR_OFF21_MSB     20
`define CBR_FN_MSB        5
`define CBR_FN_LSB        0

`define CBR_OP_SPECIAL    6'h00
`define CBR_OP_REGIMM     6'h01
`define CBR_OP_J          6'h02
`define CBR_OP_JAL        6'h03
`define CBR_OP_BEQ        6'h04
`define CBR_OP_BNE        6'h05
`define CBR_OP_GRP06      6'h06
`define CBR_OP_GRP07      6'h07
`define CBR_OP_GRP10      6'h08
`define CBR_OP_COP0       6'h10
`define CBR_OP_GRP30      6'h18
`define CBR_OP_GRP26      6'h16
`define CBR_OP_GRP27      6'h17
`define CBR_OP_BC         6'h32
`define CBR_OP_GRP66      6'h36
`define CBR_OP_BALC       6'h3a
`define CBR_OP_GRP76      6'h3e

`define CBR_RT_LIKELY_GE  5'h13
`define CBR_RT_LINK_NB    5'h10
`define CBR_RT_LINK_BR    5'h11
`define CBR_FN_JR         6'h08
`define CBR_FN_JALR       6'h09
`define CBR_FN_EXCEPTION_RETURN       6'h18
`define CBR_FN_DEBUG_RETURN      6'h1f
`define CBR_FN_WAIT       6'h20
`define CBR_CO_BIT        25

`define CBR_ZERO_REG      5'h00
`define CBR_LINK_REG      5'h1f
`define CBR_INSN_BYTES    4
`define CBR_SHIFT         2

`endif

// ===== src/cbr_pkg.sv
// types for the compact branch resolve unit
// assumes nothing outside this file
package cbr_pkg;
    typedef enum logic [15:0] {
        CBR_NONE     = 16'h0001,
        CBR_EQ       = 16'h0002,
        CBR_NE       = 16'h0004,
        CBR_SLT      = 16'h0008,
        CBR_SGE      = 16'h0010,
        CBR_ULT      = 16'h0020,
        CBR_UGE      = 16'h0040,
        CBR_ZLT      = 16'h0080,
        CBR_ZLE      = 16'h0100,
        CBR_ZGE      = 16'h0200,
        CBR_ZGT      = 16'h0400,
        CBR_ZEQ      = 16'h0800,
        CBR_ZNE      = 16'h1000,
        CBR_LIKELY   = 16'h2000
    } cbr_cond_t;

    typedef enum logic [2:0] {
        CBR_ST_IDLE   = 3'b001,
        CBR_ST_FORBID = 3'b010,
        CBR_ST_DSLOT  = 3'b100
    } cbr_state_t;
endpackage

// ===== src/cbr_decode.sv
// decoder: classifies an instruction word into a branch condition and offset form
// assumes a full 32-bit word, combinational use
`include "cbr_cfg.svh"
module cbr_decode
    import cbr_pkg::*;
(
    input  wire logic [31:0]     insn_i,
    output cbr_pkg::cbr_cond_t   cond_o,
    output logic                 wide_o,
    output logic                 link_o,
    output logic                 cti_o
);
    logic [5:0] op;
    logic [4:0] rs;
    logic [4:0] rt;
    logic [5:0] fn;
    logic       rs_z;
    logic       rt_z;

    assign op   = insn_i[`CBR_OP_MSB:`CBR_OP_LSB];
    assign rs   = insn_i[`CBR_RS_MSB:`CBR_RS_LSB];
    assign rt   = insn_i[`CBR_RT_MSB:`CBR_RT_LSB];
    assign fn   = insn_i[`CBR_FN_MSB:`CBR_FN_LSB];
    assign rs_z = (rs == `CBR_ZERO_REG);
    assign rt_z = (rt == `CBR_ZERO_REG);

    // selection uses the register fields as well as the opcode
    always_comb begin
        cond_o = CBR_NONE;
        wide_o = 1'b0;
        link_o = 1'b0;
        case (op)
            `CBR_OP_GRP06: begin
                if (!rt_z) begin
                    if (rs_z) begin
                        cond_o = CBR_ZLE;
                        link_o = 1'b1;
                    end else if (rs == rt) begin
                        cond_o = CBR_ZGE;
                        link_o = 1'b1;
                    end else begin
                        cond_o = CBR_UGE;
                    end
                end
            end
            `CBR_OP_GRP07: begin
                if (!rt_z) begin
                    if (rs_z) begin
                        cond_o = CBR_ZGT;
                        link_o = 1'b1;
                    end else if (rs == rt) begin
                        cond_o = CBR_ZLT;
                        link_o = 1'b1;
                    end else begin
                        cond_o = CBR_ULT;
                    end
                end
            end
            `CBR_OP_GRP10, `CBR_OP_GRP30: begin
                if (!rt_z) begin
                    if (rs_z) begin
                        cond_o = (op == `CBR_OP_GRP10) ? CBR_ZEQ : CBR_ZNE;
                        link_o = 1'b1;
                    end else if (rs < rt) begin
                        cond_o = (op == `CBR_OP_GRP10) ? CBR_EQ : CBR_NE;
                    end
                end
            end
            `CBR_OP_GRP26: begin
                if (!rt_z) begin
                    if (rs_z) begin
                        cond_o = CBR_ZLE;
                    end else if (rs == rt) begin
                        cond_o = CBR_ZGE;
                    end else begin
                        cond_o = CBR_SGE;
                    end
                end
            end
            `CBR_OP_GRP27: begin
                if (!rt_z) begin
                    if (rs_z) begin
                        cond_o = CBR_ZGT;
                    end else if (rs == rt) begin
                        cond_o = CBR_ZLT;
                    end else begin
                        cond_o = CBR_SLT;
                    end
                end
            end
            `CBR_OP_GRP66, `CBR_OP_GRP76: begin
                if (!rs_z) begin
                    cond_o = (op == `CBR_OP_GRP66) ? CBR_ZEQ : CBR_ZNE;
                    wide_o = 1'b1;
                end
            end
            `CBR_OP_REGIMM: begin
                if (rt == `CBR_RT_LIKELY_GE) begin
                    cond_o = CBR_LIKELY;
                    link_o = 1'b1;
                end
            end
            default: begin
                cond_o = CBR_NONE;
            end
        endcase
    end

    // control transfer classes that are refused in a forbidden slot
    always_comb begin
        case (op)
            `CBR_OP_J, `CBR_OP_JAL, `CBR_OP_BEQ, `CBR_OP_BNE,
            `CBR_OP_GRP06, `CBR_OP_GRP07, `CBR_OP_GRP26, `CBR_OP_GRP27,
            `CBR_OP_BC, `CBR_OP_BALC, `CBR_OP_GRP66, `CBR_OP_GRP76: begin
                cti_o = 1'b1;
            end
            `CBR_OP_GRP10, `CBR_OP_GRP30: begin
                cti_o = !rt_z;
            end
            `CBR_OP_REGIMM: begin
                cti_o = 1'b1;
            end
            `CBR_OP_SPECIAL: begin
                cti_o = (fn == `CBR_FN_JR) || (fn == `CBR_FN_JALR);
            end
            `CBR_OP_COP0: begin
                cti_o = insn_i[`CBR_CO_BIT] && ((fn == `CBR_FN_EXCEPTION_RETURN) ||
                        (fn == `CBR_FN_DEBUG_RETURN) || (fn == `CBR_FN_WAIT));
            end
            default: begin
                cti_o = 1'b0;
            end
        endcase
    end
endmodule

// ===== src/cbr_compare.sv
// comparator: evaluates a branch condition over two full-width operands
// assumes operands already read from the register file
module cbr_compare
    import cbr_pkg::*;
#(
    parameter int XLEN = 64
) (
    input  cbr_pkg::cbr_cond_t cond_i,
    input  wire logic [XLEN-1:0] rs_val_i,
    input  wire logic [XLEN-1:0] rt_val_i,
    output logic               taken_o
);
    logic eq;
    logic slt;
    logic ult;
    logic t_neg;
    logic t_zero;
    logic s_neg;
    logic s_zero;

    // full-width compares, signed ones as two's complement
    assign eq     = (rs_val_i == rt_val_i);
    assign slt    = ($signed(rs_val_i) < $signed(rt_val_i));
    assign ult    = (rs_val_i < rt_val_i);
    assign t_neg  = rt_val_i[XLEN-1];
    assign t_zero = ~|rt_val_i;
    assign s_neg  = rs_val_i[XLEN-1];
    assign s_zero = ~|rs_val_i;

    always_comb begin
        case (cond_i)
            CBR_EQ:     taken_o = eq;
            CBR_NE:     taken_o = !eq;
            CBR_SLT:    taken_o = slt;
            CBR_SGE:    taken_o = !slt;
            CBR_ULT:    taken_o = ult;
            CBR_UGE:    taken_o = !ult;
            CBR_ZLT:    taken_o = t_neg;
            CBR_ZLE:    taken_o = t_neg || t_zero;
            CBR_ZGE:    taken_o = !t_neg;
            CBR_ZGT:    taken_o = !t_neg && !t_zero;
            CBR_ZEQ:    taken_o = t_zero;
            CBR_ZNE:    taken_o = !t_zero;
            CBR_LIKELY: taken_o = !s_neg;
            default:    taken_o = 1'b0;
        endcase
    end
endmodule

// ===== src/cbr_unit.sv
// compact branch resolve unit: decodes, evaluates and resolves one instruction per cycle
// assumes rs/rt operand values are presented with the word; inputs synchronous to CLK_I
`include "cbr_cfg.svh"

// Behaviour
// - zero-compare-and-link compact branches write next address into register 31 always
// - link branches test rt for le, ge, lt, gt, eq, ne zero
// - le/ge zero link forms share the legacy le-zero opcode, split by registers
// - gt/lt zero link forms share the legacy gt-zero opcode, split by registers
// - eq/ne zero link forms use former add-immediate-trap opcodes
// - decode uses register fields besides bits 31-26
// - 16-bit offset shifted left two and sign-extended, reach 128 KBytes
// - link-likely branch writes address of second following instruction to register 31
// - link-likely target is delay-slot address plus 18-bit displacement
// - link-likely taken on sign bit zero; otherwise delay slot is nullified
// - compact branches have no delay slot; taken skips next instruction
// - wide eq/ne zero forms use 21-bit offset, others 16-bit
// - compact target is next instruction address plus displacement
// - register equality forms taken on equal or differing values
// - signed forms taken on rs less than, or not less than, rt
// - unsigned forms taken on rs less than, or not less than, rt
// - register-to-zero 16-bit forms test rt lt, le, ge, gt zero
// - wide zero-equality forms test rs equal or not equal zero
// - control transfer in forbidden slot of untaken compact branch raises exception
module cbr_unit
    import cbr_pkg::*;
#(
    parameter int XLEN = 64
) (
    input  wire logic              CLK_I,
    input  wire logic              RSTN_I,
    input  wire logic              VALID_I,
    input  wire logic [31:0]       INSN_I,
    input  wire logic [XLEN-1:0]   PC_I,
    input  wire logic [XLEN-1:0]   RS_VAL_I,
    input  wire logic [XLEN-1:0]   RT_VAL_I,
    output logic                   RESOLVED_O,
    output logic                   TAKEN_O,
    output logic [XLEN-1:0]        TARGET_O,
    output logic                   LINK_WE_O,
    output logic [4:0]             LINK_REG_O,
    output logic [XLEN-1:0]        LINK_DATA_O,
    output logic                   NULLIFY_O,
    output logic                   RESV_INSN_O
);
    import cbr_pkg::*;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // decode and compare
    // ----------------------------------------------------------------
    cbr_cond_t cond;
    logic      wide;
    logic      link;
    logic      control_transfer_instr;
    logic      taken;
    logic [XLEN-1:0] zero_src;

    cbr_decode u_dec (
        .insn_i (INSN_I),
        .cond_o (cond),
        .wide_o (wide),
        .link_o (link),
        .cti_o  (control_transfer_instr)
    );

    // wide zero-equality forms test rs, so rs feeds the zero-test operand
    assign zero_src = wide ? RS_VAL_I : RT_VAL_I;

    cbr_compare #(
        .XLEN (XLEN)
    ) u_cmp (
        .cond_i   (cond),
        .rs_val_i (RS_VAL_I),
        .rt_val_i (zero_src),
        .taken_o  (taken)
    );

    // ----------------------------------------------------------------
    // displacement and addresses
    // ----------------------------------------------------------------
    logic [XLEN-1:0] disp16;
    logic [XLEN-1:0] disp21;
    logic [XLEN-1:0] disp;
    logic [XLEN-1:0] pc_next;
    logic [XLEN-1:0] pc_next2;
    logic            is_br;
    logic            likely;

    // reversed-operand aliases are encoded as forward forms, no extra decode
    assign is_br    = VALID_I && (cond != CBR_NONE);
    assign likely   = (cond == CBR_LIKELY);
    assign disp16   = {{(XLEN-18){INSN_I[`CBR_OFF16_MSB]}},
                       INSN_I[`CBR_OFF16_MSB:0], 2'b00};
    assign disp21   = {{(XLEN-23){INSN_I[`CBR_OFF21_MSB]}},
                       INSN_I[`CBR_OFF21_MSB:0], 2'b00};
    assign disp     = wide ? disp21 : disp16;
    assign pc_next  = PC_I + XLEN'(`CBR_INSN_BYTES);
    assign pc_next2 = PC_I + XLEN'(2 * `CBR_INSN_BYTES);

    // ----------------------------------------------------------------
    // slot tracking
    // ----------------------------------------------------------------
    cbr_state_t state_reg;
    cbr_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CBR_ST_IDLE, CBR_ST_FORBID, CBR_ST_DSLOT: begin
                if (VALID_I) begin
                    if (is_br && likely) begin
                        state_next = CBR_ST_DSLOT;
                    end else if (is_br && !taken) begin
                        // untaken compact branch: next word is its forbidden slot
                        state_next = CBR_ST_FORBID;
                    end else begin
                        state_next = CBR_ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = CBR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= CBR_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // resolution outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            RESOLVED_O <= 1'b0;
            TAKEN_O    <= 1'b0;
            TARGET_O   <= '0;
            NULLIFY_O  <= 1'b0;
        end else begin
            RESOLVED_O <= is_br;
            TAKEN_O    <= is_br && taken;
            // both forms add to the address after the branch
            TARGET_O   <= pc_next + disp;
            NULLIFY_O  <= is_br && likely && !taken;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            LINK_WE_O   <= 1'b0;
            LINK_REG_O  <= 5'h00;
            LINK_DATA_O <= '0;
        end else begin
            // link written whether taken or not
            LINK_WE_O   <= is_br && link;
            LINK_REG_O  <= `CBR_LINK_REG;
            LINK_DATA_O <= likely ? pc_next2 : pc_next;
        end
    end

    // a transfer in the forbidden slot is refused
    always_ff @(posedge CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            RESV_INSN_O <= 1'b0;
        end else begin
            RESV_INSN_O <= VALID_I && control_transfer_instr && (state_reg == CBR_ST_FORBID);
        end
    end
endmodule

// ===== tb/cbr_unit_monitor.sv
// checker for the compact branch resolve unit, built on its top ports only
// assumes it is bound onto cbr_unit with a matching XLEN
module cbr_unit_monitor #(
    parameter int XLEN = 64
) (
    input wire logic            CLK_I,
    input wire logic            RSTN_I,
    input wire logic            VALID_I,
    input wire logic [31:0]     INSN_I,
    input wire logic [XLEN-1:0] PC_I,
    input wire logic [XLEN-1:0] RS_VAL_I,
    input wire logic [XLEN-1:0] RT_VAL_I,
    input wire logic            RESOLVED_O,
    input wire logic            TAKEN_O,
    input wire logic [XLEN-1:0] TARGET_O,
    input wire logic            LINK_WE_O,
    input wire logic [4:0]      LINK_REG_O,
    input wire logic [XLEN-1:0] LINK_DATA_O,
    input wire logic            NULLIFY_O,
    input wire logic            RESV_INSN_O
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------
    // word fields and expected targets
    // ------
    logic [5:0]      op;
    logic [4:0]      rs;
    logic [4:0]      rt;
    logic            two_reg;
    logic            rs_neg;
    logic [XLEN-1:0] t16;
    logic [XLEN-1:0] t21;

    assign op      = INSN_I[31:26];
    assign rs      = INSN_I[25:21];
    assign rt      = INSN_I[20:16];
    assign rs_neg  = RS_VAL_I[XLEN-1];
    assign two_reg = VALID_I && rs != 5'h00 && rt != 5'h00 && rs != rt;
    assign t16     = PC_I + 3'h4 + {{(XLEN-18){INSN_I[15]}}, INSN_I[15:0], 2'b00};
    assign t21     = PC_I + 3'h4 + {{(XLEN-23){INSN_I[20]}}, INSN_I[20:0], 2'b00};

    // ------
    // properties
    // ------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    sequence s_untaken;
        RESOLVED_O && !TAKEN_O && !NULLIFY_O;
    endsequence
    sequence s_jump;
        VALID_I && op == 6'h02;
    endsequence

    a_link_reg_fixed: assert property (LINK_WE_O |-> LINK_REG_O == 5'h1f)
        else $error("link write not aimed at register 31");
    a_eqz_link_call: assert property (VALID_I && op == 6'h08 && rs == 5'h00 && rt != 5'h00
        |=> LINK_WE_O && LINK_DATA_O == $past(PC_I) + 3'h4 && TAKEN_O == ($past(RT_VAL_I) == '0))
        else $error("eq zero link call wrong");
    a_likely_call: assert property (VALID_I && op == 6'h01 && rt == 5'h13 |=>
        RESOLVED_O && TARGET_O == $past(t16) && LINK_DATA_O == $past(PC_I) + 4'h8
        && NULLIFY_O == $past(rs_neg) && TAKEN_O == !$past(rs_neg))
        else $error("likely call wrong");
    a_narrow_target: assert property (VALID_I && op == 6'h16 && rt != 5'h00
        |=> RESOLVED_O && TARGET_O == $past(t16) && !LINK_WE_O)
        else $error("narrow target wrong");
    a_wide_eqz: assert property (VALID_I && op == 6'h36 && rs != 5'h00 |=>
        RESOLVED_O && TARGET_O == $past(t21) && TAKEN_O == ($past(RS_VAL_I) == '0))
        else $error("wide eq zero branch wrong");
    a_eq_compare: assert property (VALID_I && op == 6'h08 && rs != 5'h00 && rs < rt
        |=> RESOLVED_O && TAKEN_O == ($past(RS_VAL_I) == $past(RT_VAL_I)))
        else $error("equal compare wrong");
    a_signed_less: assert property (two_reg && op == 6'h17 |=>
        TAKEN_O == ($signed($past(RS_VAL_I)) < $signed($past(RT_VAL_I))))
        else $error("signed less compare wrong");
    a_unsigned_less: assert property (two_reg && op == 6'h07 |=>
        TAKEN_O == ($past(RS_VAL_I) < $past(RT_VAL_I)))
        else $error("unsigned less compare wrong");
    a_forbid_slot_resv: assert property (s_untaken ##0 s_jump |=> RESV_INSN_O)
        else $error("forbidden slot jump not refused");
    a_taken_no_resv: assert property (TAKEN_O && !NULLIFY_O ##0 s_jump |=> !RESV_INSN_O)
        else $error("refusal after taken branch");
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the compact branch resolve unit
// assumes cbr_pkg, cbr_unit and cbr_unit_monitor are compiled before it
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int          XLEN = 64;
    localparam logic [63:0] Z    = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ONE  = 64'h0000_0000_0000_0001;
    localparam logic [63:0] NEG  = 64'hffff_ffff_ffff_ffff;
    localparam logic [63:0] MINV = 64'h8000_0000_0000_0000;
    localparam logic [63:0] BIG  = 64'h0000_0001_0000_0000;
    localparam logic [31:0] JMP  = 32'h0800_0010;
    localparam logic [20:0] R5   = 21'h05_0004;
    localparam logic [20:0] R3   = 21'h03_0004;

    logic            CLK_I;
    logic            RSTN_I;
    logic            VALID_I;
    logic [31:0]     INSN_I;
    logic [63:0]     PC_I;
    logic [63:0]     RS_VAL_I;
    logic [63:0]     RT_VAL_I;
    logic            RESOLVED_O;
    logic            TAKEN_O;
    logic [63:0]     TARGET_O;
    logic            LINK_WE_O;
    logic [4:0]      LINK_REG_O;
    logic [63:0]     LINK_DATA_O;
    logic            NULLIFY_O;
    logic            RESV_INSN_O;
    int              error_cnt;
    int              check_count;
    logic [63:0]     pc;
    logic            lnk;

    cbr_unit #(.XLEN(XLEN)) dut_u (
        .CLK_I(CLK_I), .RSTN_I(RSTN_I), .VALID_I(VALID_I), .INSN_I(INSN_I), .PC_I(PC_I),
        .RS_VAL_I(RS_VAL_I), .RT_VAL_I(RT_VAL_I), .RESOLVED_O(RESOLVED_O), .TAKEN_O(TAKEN_O),
        .TARGET_O(TARGET_O), .LINK_WE_O(LINK_WE_O), .LINK_REG_O(LINK_REG_O),
        .LINK_DATA_O(LINK_DATA_O), .NULLIFY_O(NULLIFY_O), .RESV_INSN_O(RESV_INSN_O)
    );

    // ------
    // shared tasks
    // ------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    // one word at the falling edge, outputs looked at just after the taking edge
    task automatic put(input logic v, input logic [31:0] w, input logic [63:0] a, b);
        @(negedge CLK_I);
        VALID_I  = v;
        INSN_I   = w;
        PC_I     = pc;
        RS_VAL_I = a;
        RT_VAL_I = b;
        @(posedge CLK_I);
        #1;
    endtask

    // narrow forms carry rt in off[20:16]; an untaken branch gets a plain word after it
    task automatic br(input logic [5:0] op, input logic [4:0] rs, input logic [20:0] off,
                      input logic [63:0] a, b, input logic tk);
        logic [63:0] t;
        t = (op == 6'h36 || op == 6'h3e) ? {{41{off[20]}}, off, 2'b00}
                                         : {{46{off[15]}}, off[15:0], 2'b00};
        put(1'b1, {op, rs, off}, a, b);
        chk(RESOLVED_O, 1'b1);
        chk(TAKEN_O, tk);
        chk(TARGET_O, pc + 3'h4 + t);
        chk(LINK_WE_O, lnk);
        if (lnk) begin
            chk(LINK_DATA_O, pc + 3'h4);
            chk(LINK_REG_O, 5'h1f);
        end
        chk(NULLIFY_O, 1'b0);
        pc = pc + 12'h100;
        if (!tk) begin
            put(1'b1, 32'h0000_0000, Z, Z);
            chk(RESV_INSN_O, 1'b0);
        end
    endtask

    // ------
    // scenarios
    // ------
    task automatic t_reset();
        repeat (12) @(posedge CLK_I);
        #1;
        chk(LINK_WE_O, 1'b0);
        @(negedge CLK_I);
        RSTN_I = 1'b1;
        repeat (3) @(posedge CLK_I);
        #1;
        chk(LINK_REG_O, 5'h1f);
    endtask

    task automatic t_link_zero();
        lnk = 1'b1;
        br(6'h08, 5'h00, R5, Z, Z, 1'b1);
        br(6'h08, 5'h00, R5, Z, BIG, 1'b0);
        br(6'h18, 5'h00, R5, Z, BIG, 1'b1);
        br(6'h18, 5'h00, R5, Z, Z, 1'b0);
        br(6'h06, 5'h00, R5, Z, Z, 1'b1);
        br(6'h06, 5'h00, R5, Z, BIG, 1'b0);
        br(6'h06, 5'h05, R5, Z, Z, 1'b1);
        br(6'h06, 5'h05, R5, MINV, MINV, 1'b0);
        br(6'h07, 5'h00, R5, Z, BIG, 1'b1);
        br(6'h07, 5'h00, R5, Z, Z, 1'b0);
        br(6'h07, 5'h05, R5, NEG, NEG, 1'b1);
        br(6'h07, 5'h05, R5, Z, Z, 1'b0);
        lnk = 1'b0;
    endtask

    task automatic t_reg_cmp();
        br(6'h08, 5'h03, R5, BIG, BIG, 1'b1);
        br(6'h08, 5'h03, R5, BIG, ONE, 1'b0);
        br(6'h18, 5'h03, R5, Z, BIG, 1'b1);
        br(6'h18, 5'h03, R5, ONE, ONE, 1'b0);
        br(6'h16, 5'h03, R5, NEG, ONE, 1'b0);
        br(6'h16, 5'h03, R5, ONE, ONE, 1'b1);
        br(6'h17, 5'h03, R5, NEG, ONE, 1'b1);
        br(6'h17, 5'h05, R3, NEG, ONE, 1'b1);
        br(6'h06, 5'h03, R5, NEG, ONE, 1'b1);
        br(6'h06, 5'h03, R5, Z, ONE, 1'b0);
        br(6'h07, 5'h03, R5, NEG, ONE, 1'b0);
        br(6'h07, 5'h03, R5, ONE, BIG, 1'b1);
    endtask

    task automatic t_zero_cmp();
        br(6'h16, 5'h00, 21'h05_8000, Z, Z, 1'b1);
        br(6'h16, 5'h00, R5, Z, ONE, 1'b0);
        br(6'h16, 5'h05, 21'h05_7fff, NEG, NEG, 1'b0);
        br(6'h16, 5'h05, R5, Z, Z, 1'b1);
        br(6'h17, 5'h00, R5, Z, Z, 1'b0);
        br(6'h17, 5'h00, R5, Z, BIG, 1'b1);
        br(6'h17, 5'h05, R5, MINV, MINV, 1'b1);
        br(6'h17, 5'h05, R5, BIG, BIG, 1'b0);
        br(6'h36, 5'h05, 21'h10_0000, Z, NEG, 1'b1);
        br(6'h36, 5'h05, 21'h0f_ffff, BIG, Z, 1'b0);
        br(6'h3e, 5'h05, 21'h1f_ffff, BIG, Z, 1'b1);
        br(6'h3e, 5'h05, R5, Z, NEG, 1'b0);
    endtask

    task automatic t_likely();
        logic [63:0] a;
        for (int i = 0; i < 2; i++) begin
            a = i ? MINV : BIG;
            put(1'b1, {6'h01, 5'h04, 5'h13, 16'hfffe}, a, Z);
            chk(LINK_WE_O, 1'b1);
            chk(TAKEN_O, !a[63]);
            chk(NULLIFY_O, a[63]);
            chk(TARGET_O, pc - 3'h4);
            chk(LINK_DATA_O, pc + 4'h8);
            put(1'b1, 32'h0000_0000, Z, Z);
            pc = pc + 12'h100;
        end
    endtask

    task automatic t_forbid();
        put(1'b1, {6'h08, 5'h03, R5}, Z, ONE);
        put(1'b1, JMP, Z, Z);
        chk(RESV_INSN_O, 1'b1);
        put(1'b1, {6'h18, 5'h03, R5}, Z, Z);
        put(1'b0, JMP, Z, Z);
        put(1'b1, JMP, Z, Z);
        chk(RESV_INSN_O, 1'b1);
        put(1'b1, {6'h08, 5'h03, R5}, ONE, ONE);
        put(1'b1, JMP, Z, Z);
        chk(RESV_INSN_O, 1'b0);
        put(1'b1, {6'h18, 5'h03, R5}, ONE, ONE);
        put(1'b1, 32'h4200_0018, Z, Z);
        chk(RESV_INSN_O, 1'b1);
        put(1'b0, JMP, Z, Z);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------
    // clock, watchdog, main sequence
    // ------
    initial begin
        CLK_I = 1'b0;
        forever #2 CLK_I = ~CLK_I;
    end

    initial begin
        #20000;
        error_cnt++;
        stop_test();
    end

    initial begin
        RSTN_I      = 1'b0;
        VALID_I     = 1'b0;
        INSN_I      = '0;
        PC_I        = '0;
        RS_VAL_I    = '0;
        RT_VAL_I    = '0;
        error_cnt   = 0;
        check_count = 0;
        pc          = 64'h0000_0000_0000_1000;
        lnk         = 1'b0;
        t_reset();
        t_link_zero();
        t_reg_cmp();
        t_zero_cmp();
        t_likely();
        t_forbid();
        stop_test();
    end
endmodule

bind cbr_unit cbr_unit_monitor #(.XLEN(XLEN)) mon_u (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .VALID_I(VALID_I), .INSN_I(INSN_I), .PC_I(PC_I),
    .RS_VAL_I(RS_VAL_I), .RT_VAL_I(RT_VAL_I), .RESOLVED_O(RESOLVED_O), .TAKEN_O(TAKEN_O),
    .TARGET_O(TARGET_O), .LINK_WE_O(LINK_WE_O), .LINK_REG_O(LINK_REG_O),
    .LINK_DATA_O(LINK_DATA_O), .NULLIFY_O(NULLIFY_O), .RESV_INSN_O(RESV_INSN_O)
);
